// File: hw/srs_consts.svh
// Register indices, field positions, reset values and timing counts for SYSREF capture
`ifndef SRS_CONSTS_SVH
`define SRS_CONSTS_SVH
// Register indices (byte address is four times the index)
`define SRS_IDX_CLKDIV 13'h010B
`define SRS_IDX_CTRL 13'h0120
`define SRS_IDX_IGNORE 13'h0121
`define SRS_IDX_TSDLY 13'h0123
`define SRS_IDX_MONITOR 13'h0128
`define SRS_IDX_SYNCMODE 13'h01FF
`define SRS_IDX_APPMODE 13'h0200
`define SRS_IDX_CBF_LO 13'h0559
`define SRS_IDX_CBF_HI 13'h055A
`define SRS_IDX_CBCNT 13'h058F
// Field positions
`define SRS_SYNCMODE_BIT 0
`define SRS_CTRL_MODE_LSB 1
`define SRS_CTRL_MODE_MSB 2
`define SRS_CTRL_EDGE_BIT 3
`define SRS_CTRL_TRANS_BIT 4
`define SRS_CBF0_LSB 0
`define SRS_CBF1_LSB 4
`define SRS_CBCNT_LSB 6
`define SRS_APPMODE_DEC_BIT 0
// Field values
`define SRS_MODE_OFF 2'h0
`define SRS_MODE_CONT 2'h1
`define SRS_MODE_NSHOT 2'h2
`define SRS_CBF_SYSREF 3'h5
// Reset values
`define SRS_RST_BYTE 8'h00
// Monitor nibble for best margin
`define SRS_NIB_BEST 4'h8
// Pipeline stages from pin to marker pulse (sync 2, detect 1, delay stage 1)
`define SRS_SMP_LAT 4
`endif

// File: hw/srs_delay.sv
// Programmable delay from a captured SYSREF event to the timestamp marker
`timescale 1ns/1ns
module srs_delay #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Event and delay
   input wire logic start,
   input wire logic [W-1:0] delay,
   // Marker
   output logic mark
);
   typedef struct packed {
      logic busy;
      logic [W-1:0] cnt;
      logic mark;
   } srs_delay_state_t;

   srs_delay_state_t st_reg, st_next;

   // Elaboration check on the counter width
   if (W < 1 || W > 16) begin
      $error("srs_delay width out of range");
   end

   // ----------------------------------------
   // Countdown
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.mark = 1'b0;
      if (start) begin
         st_next.busy = (delay != '0);
         st_next.cnt = delay;
         st_next.mark = (delay == '0);
      end else if (st_reg.busy) begin
         st_next.cnt = st_reg.cnt - 1'b1;
         if (st_reg.cnt == {{(W-1){1'b0}}, 1'b1}) begin
            st_next.busy = 1'b0;
            st_next.mark = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign mark = st_reg.mark;
endmodule

// File: hw/srs_edge.sv
// SYSREF pin synchronizer, transition detector and setup/hold margin monitor
`timescale 1ns/1ns
`include "srs_consts.svh"
module srs_edge (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Configuration
   input wire logic edge_sel,
   input wire logic trans_sel,
   // SYSREF pin
   input wire logic sysref_pin,
   // Results
   output logic evt,
   output logic [3:0] setup_nib,
   output logic [3:0] hold_nib
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic prev;
      logic [3:0] run;
      logic [3:0] setup;
      logic [3:0] hold;
      logic hold_on;
      logic evt;
   } srs_edge_state_t;

   srs_edge_state_t st_reg, st_next;
   logic cur;

   // ----------------------------------------
   // Detection
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.s1 = sysref_pin;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      cur = edge_sel ? st_reg.s3 : st_reg.s2;
      st_next.prev = cur;
      st_next.evt = (st_reg.prev == trans_sel) && (cur != trans_sel);
      if (cur == trans_sel) begin
         if (st_reg.run != 4'hF) begin
            st_next.run = st_reg.run + 4'h1;
         end
      end else begin
         st_next.run = 4'h0;
      end
      if (st_next.evt) begin
         st_next.setup = (st_reg.run >= `SRS_NIB_BEST) ? `SRS_NIB_BEST : st_reg.run;
         st_next.hold = 4'h0;
         st_next.hold_on = 1'b1;
      end else if (st_reg.hold_on) begin
         if (cur != trans_sel && st_reg.hold != `SRS_NIB_BEST) begin
            st_next.hold = st_reg.hold + 4'h1;
         end else begin
            st_next.hold_on = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign evt = st_reg.evt;
   assign setup_nib = st_reg.setup;
   assign hold_nib = st_reg.hold;
endmodule

// File: hw/srs_pkg.sv
// Types for SYSREF capture and multichip synchronization
package srs_pkg;
   typedef struct packed {
      logic [31:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } srs_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } srs_apb_rsp_t;
   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } srs_smp_in_t;
   typedef struct packed {
      logic valid;
      logic [15:0] data;
      logic [2:0] ctrl;
   } srs_smp_out_t;
   typedef struct packed {
      logic clk_div;
      logic ddc;
      logic sig_mon;
      logic link;
   } srs_resync_t;
endpackage

// File: hw/srs_top.sv
// SYSREF capture and multichip synchronization top with APB register slave
//
// Added by the designer: the APB register port.
`timescale 1ns/1ns
`include "srs_consts.svh"
module srs_top #(
   parameter int NCH = 4,
   parameter int DLY_W = 8
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // APB slave
   input wire srs_pkg::srs_apb_req_t apb_req,
   output srs_pkg::srs_apb_rsp_t apb_rsp,
   // SYSREF pin
   input wire logic sysref_pin,
   // Sample streams
   input wire srs_pkg::srs_smp_in_t [NCH-1:0] smp_in,
   output srs_pkg::srs_smp_out_t [NCH-1:0] smp_out,
   // Resync strobes
   output srs_pkg::srs_resync_t resync
);
   localparam int LAT = `SRS_SMP_LAT;

   typedef struct packed {
      logic [7:0] clkdiv;
      logic [7:0] ctrl;
      logic [7:0] ignore;
      logic [7:0] tsdly;
      logic [7:0] syncmode;
      logic [7:0] appmode;
      logic [7:0] cbf_lo;
      logic [7:0] cbf_hi;
      logic [7:0] cbcnt;
      logic [3:0] ign_cnt;
      srs_pkg::srs_apb_rsp_t rsp;
      srs_pkg::srs_resync_t resync;
      logic [LAT-1:0][NCH-1:0] vpipe;
      logic [LAT-1:0][NCH-1:0][15:0] dpipe;
      srs_pkg::srs_smp_out_t [NCH-1:0] out;
   } srs_top_state_t;

   srs_top_state_t st_reg, st_next;
   logic evt;
   logic mark;
   logic [3:0] setup_nib;
   logic [3:0] hold_nib;
   logic act;
   logic ts_en;
   logic [1:0] mode;
   logic [2:0] cmask;
   logic apb_fire;
   logic hit;
   logic [7:0] rd;

   // Elaboration checks on the parameters
   if (NCH < 1 || NCH > 16) begin
      $error("srs_top channel count out of range");
   end
   if (DLY_W != 8) begin
      $error("srs_top delay width must match the 8-bit register");
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] reg_addr(input logic [12:0] idx);
      reg_addr = {17'h0_0000, idx, 2'b00};
   endfunction

   function automatic logic cbit_on(input logic [2:0] func, input logic [1:0] cnt, input logic [1:0] k);
      cbit_on = (func == `SRS_CBF_SYSREF) && (cnt > k);
   endfunction

   // ----------------------------------------
   // Submodules
   // ----------------------------------------
   srs_edge u_edge (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .edge_sel(st_reg.ctrl[`SRS_CTRL_EDGE_BIT]),
      .trans_sel(st_reg.ctrl[`SRS_CTRL_TRANS_BIT]),
      .sysref_pin(sysref_pin),
      .evt(evt),
      .setup_nib(setup_nib),
      .hold_nib(hold_nib)
   );

   srs_delay #(
      .W(DLY_W)
   ) u_delay (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .start(act && ts_en),
      .delay(st_reg.tsdly[DLY_W-1:0]),
      .mark(mark)
   );

   // ----------------------------------------
   // Event qualification
   // ----------------------------------------
   always_comb begin
      mode = st_reg.ctrl[`SRS_CTRL_MODE_MSB:`SRS_CTRL_MODE_LSB];
      act = 1'b0;
      if (evt && mode != `SRS_MODE_OFF) begin
         if (mode == `SRS_MODE_NSHOT) begin
            act = (st_reg.ign_cnt == 4'h0);
         end else begin
            act = 1'b1;
         end
      end
      ts_en = st_reg.syncmode[`SRS_SYNCMODE_BIT] && !st_reg.appmode[`SRS_APPMODE_DEC_BIT];
      cmask[0] = cbit_on(st_reg.cbf_lo[`SRS_CBF0_LSB +: 3], st_reg.cbcnt[`SRS_CBCNT_LSB +: 2], 2'd0);
      cmask[1] = cbit_on(st_reg.cbf_lo[`SRS_CBF1_LSB +: 3], st_reg.cbcnt[`SRS_CBCNT_LSB +: 2], 2'd1);
      cmask[2] = cbit_on(st_reg.cbf_hi[`SRS_CBF0_LSB +: 3], st_reg.cbcnt[`SRS_CBCNT_LSB +: 2], 2'd2);
   end

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   always_comb begin
      apb_fire = apb_req.psel && apb_req.penable && st_reg.rsp.pready;
      hit = 1'b1;
      rd = 8'h00;
      if (apb_req.paddr == reg_addr(`SRS_IDX_CLKDIV)) begin
         rd = st_reg.clkdiv;
      end else if (apb_req.paddr == reg_addr(`SRS_IDX_CTRL)) begin
         rd = st_reg.ctrl;
      end else if (apb_req.paddr == reg_addr(`SRS_IDX_IGNORE)) begin
         rd = st_reg.ignore;
      end else if (apb_req.paddr == reg_addr(`SRS_IDX_TSDLY)) begin
         rd = st_reg.tsdly;
      end else if (apb_req.paddr == reg_addr(`SRS_IDX_MONITOR)) begin
         rd = {hold_nib, setup_nib};
      end else if (apb_req.paddr == reg_addr(`SRS_IDX_SYNCMODE)) begin
         rd = st_reg.syncmode;
      end else if (apb_req.paddr == reg_addr(`SRS_IDX_APPMODE)) begin
         rd = st_reg.appmode;
      end else if (apb_req.paddr == reg_addr(`SRS_IDX_CBF_LO)) begin
         rd = st_reg.cbf_lo;
      end else if (apb_req.paddr == reg_addr(`SRS_IDX_CBF_HI)) begin
         rd = st_reg.cbf_hi;
      end else if (apb_req.paddr == reg_addr(`SRS_IDX_CBCNT)) begin
         rd = st_reg.cbcnt;
      end else begin
         hit = 1'b0;
      end
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      // Bus handshake: one wait cycle, then ready
      st_next.rsp.pready = apb_req.psel && apb_req.penable && !st_reg.rsp.pready;
      if (st_next.rsp.pready) begin
         st_next.rsp.prdata = (apb_req.pwrite || !hit) ? 32'h0000_0000 : {24'h00_0000, rd};
         st_next.rsp.pslverr = !hit;
      end else begin
         st_next.rsp.prdata = 32'h0000_0000;
         st_next.rsp.pslverr = 1'b0;
      end
      // Register writes
      if (apb_fire && apb_req.pwrite && hit) begin
         if (apb_req.paddr == reg_addr(`SRS_IDX_CLKDIV)) begin
            st_next.clkdiv = apb_req.pwdata[7:0];
         end else if (apb_req.paddr == reg_addr(`SRS_IDX_CTRL)) begin
            st_next.ctrl = apb_req.pwdata[7:0];
         end else if (apb_req.paddr == reg_addr(`SRS_IDX_IGNORE)) begin
            st_next.ignore = {4'h0, apb_req.pwdata[3:0]};
         end else if (apb_req.paddr == reg_addr(`SRS_IDX_TSDLY)) begin
            st_next.tsdly = apb_req.pwdata[7:0];
         end else if (apb_req.paddr == reg_addr(`SRS_IDX_SYNCMODE)) begin
            st_next.syncmode = {7'h00, apb_req.pwdata[`SRS_SYNCMODE_BIT]};
         end else if (apb_req.paddr == reg_addr(`SRS_IDX_APPMODE)) begin
            st_next.appmode = {7'h00, apb_req.pwdata[`SRS_APPMODE_DEC_BIT]};
         end else if (apb_req.paddr == reg_addr(`SRS_IDX_CBF_LO)) begin
            st_next.cbf_lo = apb_req.pwdata[7:0];
         end else if (apb_req.paddr == reg_addr(`SRS_IDX_CBF_HI)) begin
            st_next.cbf_hi = apb_req.pwdata[7:0];
         end else if (apb_req.paddr == reg_addr(`SRS_IDX_CBCNT)) begin
            st_next.cbcnt = apb_req.pwdata[7:0];
         end
         if (apb_req.paddr == reg_addr(`SRS_IDX_CTRL) || apb_req.paddr == reg_addr(`SRS_IDX_IGNORE)) begin
            st_next.ign_cnt = (apb_req.paddr == reg_addr(`SRS_IDX_IGNORE)) ? apb_req.pwdata[3:0]
                              : st_reg.ignore[3:0];
         end
      end
      // N-shot ignore countdown and self clear (hardware wins over a write)
      if (evt && mode == `SRS_MODE_NSHOT) begin
         if (st_reg.ign_cnt != 4'h0) begin
            st_next.ign_cnt = st_reg.ign_cnt - 4'h1;
         end else begin
            st_next.ctrl[`SRS_CTRL_MODE_MSB:`SRS_CTRL_MODE_LSB] = `SRS_MODE_OFF;
            st_next.ign_cnt = st_reg.ignore[3:0];
         end
      end
      // Normal mode resync strobes
      st_next.resync.clk_div = act && !st_reg.syncmode[`SRS_SYNCMODE_BIT];
      st_next.resync.ddc = act && !st_reg.syncmode[`SRS_SYNCMODE_BIT];
      st_next.resync.sig_mon = act && !st_reg.syncmode[`SRS_SYNCMODE_BIT];
      st_next.resync.link = act && !st_reg.syncmode[`SRS_SYNCMODE_BIT];
      // Equal latency sample pipeline on every channel
      for (int c = 0; c < NCH; c++) begin
         st_next.vpipe[0][c] = smp_in[c].valid;
         st_next.dpipe[0][c] = smp_in[c].data;
      end
      for (int s = 1; s < LAT; s++) begin
         st_next.vpipe[s] = st_reg.vpipe[s-1];
         st_next.dpipe[s] = st_reg.dpipe[s-1];
      end
      for (int c = 0; c < NCH; c++) begin
         st_next.out[c].valid = st_reg.vpipe[LAT-1][c];
         st_next.out[c].data = st_reg.dpipe[LAT-1][c];
         st_next.out[c].ctrl = mark ? cmask : 3'b000;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign apb_rsp = st_reg.rsp;
   assign smp_out = st_reg.out;
   assign resync = st_reg.resync;
endmodule

// File: testbench/srs_assertions.sv
// Concurrent checks on the ports of the SYSREF capture top
`timescale 1ns/1ns
`include "srs_consts.svh"
module srs_assertions #(
   parameter int NCH = 4,
   parameter int DLY_W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // APB
   input wire srs_pkg::srs_apb_req_t apb_req,
   input wire srs_pkg::srs_apb_rsp_t apb_rsp,
   // SYSREF and streams
   input wire logic sysref_pin,
   input wire srs_pkg::srs_smp_in_t [NCH-1:0] smp_in,
   input wire srs_pkg::srs_smp_out_t [NCH-1:0] smp_out,
   input wire srs_pkg::srs_resync_t resync
);
   logic pin_reg;
   logic [3:0] quiet_reg;
   logic [2:0] up_reg;
   // ----------------------------------------
   // Helper counters
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_reg <= 1'b0;
         quiet_reg <= 4'hF;
         up_reg <= 3'h0;
      end else begin
         pin_reg <= sysref_pin;
         if (sysref_pin != pin_reg) begin
            quiet_reg <= 4'h0;
         end else if (quiet_reg != 4'hF) begin
            quiet_reg <= quiet_reg + 4'h1;
         end
         if (up_reg != 3'h7) begin
            up_reg <= up_reg + 3'h1;
         end
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence setup_s;
      apb_req.psel && !apb_req.penable;
   endsequence
   sequence access_s;
      apb_req.psel && apb_req.penable;
   endsequence
   sequence mon_rd_s;
      apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == {17'h0_0000, `SRS_IDX_MONITOR, 2'b00};
   endsequence
   apb_answer_a: assert property (setup_s ##1 access_s |-> !apb_rsp.pready ##1 apb_rsp.pready)
      else $error("APB answer not in second access cycle");
   ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready held longer than one cycle");
   refuse_zero_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0000_0000)
      else $error("Refused access with data or without ready");
   monitor_range_a: assert property (mon_rd_s |-> apb_rsp.prdata[31:8] == 24'h00_0000 &&
      apb_rsp.prdata[7:4] <= 4'h8 && apb_rsp.prdata[3:0] <= 4'h8)
      else $error("Monitor nibble out of range");
   resync_equal_a: assert property (resync != 4'h0 |-> resync == 4'hF)
      else $error("Resync strobes differ");
   resync_pulse_a: assert property (resync.link |=> !resync.link)
      else $error("Resync longer than one cycle");
   resync_cause_a: assert property (resync.link |-> quiet_reg <= 4'h8)
      else $error("Resync without recent pin transition");
   mark_align_a: assert property (smp_out[0].ctrl == smp_out[NCH-1].ctrl)
      else $error("Markers differ between channels");
   mark_excl_a: assert property (smp_out[0].ctrl != 3'h0 |-> !resync.link)
      else $error("Marker together with resync");
   pipe_latency_a: assert property (up_reg == 3'h7 |-> smp_out[0].valid == $past(smp_in[0].valid, 5) &&
      smp_out[0].data == $past(smp_in[0].data, 5))
      else $error("Sample latency wrong");
endmodule
bind srs_top srs_assertions #(.NCH(NCH), .DLY_W(DLY_W)) chk_u (.clk(clk), .rst(rst), .ce(ce), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .sysref_pin(sysref_pin), .smp_in(smp_in), .smp_out(smp_out), .resync(resync));

// File: testbench/srs_sysref_src.sv
// Behavioural system clock source driving the SYSREF pin
`timescale 1ns/1ns
module srs_sysref_src (
   // Clock
   input wire logic clk,
   // SYSREF output
   output logic sysref_pin
);
   initial sysref_pin = 1'b0;
   // Pulse high for hi cycles then low for lo; back-to-back calls repeat every hi+lo+1 cycles
   // Pulses are sent only on request, never as a free-running train
   task automatic pulse(input int hi, input int lo);
      @(posedge clk);
      sysref_pin <= 1'b1;
      repeat (hi) @(posedge clk); // Width is hi clocks, set by the caller
      sysref_pin <= 1'b0;
      repeat (lo) @(posedge clk);
   endtask
endmodule

// File: testbench/srs_top_bench.sv
// Self-checking bench for the SYSREF capture top
`timescale 1ns/1ns
`include "srs_consts.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
   $display("Error %0t: got %h expected %h", $time, (a), (b)); end end
module srs_top_bench;
   localparam int NCH = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sysref_pin;
   srs_pkg::srs_apb_req_t req = '0;
   srs_pkg::srs_apb_rsp_t rsp;
   srs_pkg::srs_smp_in_t [NCH-1:0] smp_in = '0;
   srs_pkg::srs_smp_out_t [NCH-1:0] smp_out;
   srs_pkg::srs_resync_t resync;
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;
   int n_rs = 0;
   int n_mk = 0;
   int mk_cyc = 0;
   int lat = 0;
   int d0 = 0;
   logic [31:0] rdat;
   logic rerr;
   logic [12:0] ri [9] = '{`SRS_IDX_CLKDIV, `SRS_IDX_CTRL, `SRS_IDX_IGNORE, `SRS_IDX_TSDLY, `SRS_IDX_SYNCMODE,
      `SRS_IDX_APPMODE, `SRS_IDX_CBF_LO, `SRS_IDX_CBF_HI, `SRS_IDX_CBCNT};
   logic [7:0] rv [9] = '{8'h03, 8'h18, 8'h0F, 8'hA5, 8'h01, 8'h01, 8'h55, 8'h05, 8'hC0};
   always #5 clk = ~clk;
   srs_top #(.NCH(NCH), .DLY_W(8)) dut_u (.clk(clk), .rst(rst), .ce(1'b1), .apb_req(req), .apb_rsp(rsp),
      .sysref_pin(sysref_pin), .smp_in(smp_in), .smp_out(smp_out), .resync(resync));
   srs_sysref_src src_u (.clk(clk), .sysref_pin(sysref_pin));
   // ----------------------------------------
   // Sample stream and event counters
   // ----------------------------------------
   always @(posedge clk) begin
      cyc <= cyc + 1;
      for (int c = 0; c < NCH; c++) begin
         smp_in[c] <= {1'b1, 16'(cyc + c)};
      end
      if (resync.link === 1'b1) begin
         n_rs <= n_rs + 1;
      end
      if (smp_out[0].ctrl[0] === 1'b1) begin
         n_mk <= n_mk + 1;
         mk_cyc <= cyc;
      end
      `CHK(smp_out[0].ctrl[2:1], 2'b00)
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task report_and_stop();
      $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   function automatic logic [31:0] ad(input logic [12:0] i);
      return {17'h0_0000, i, 2'b00};
   endfunction
   task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      req.paddr <= a;
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= wr;
      req.pwdata <= wd;
      @(posedge clk);
      req.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 16);
      rdat = rsp.prdata;
      rerr = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      if (n >= 16) begin
         n_mismatch++;
         report_and_stop();
      end
      @(posedge clk);
   endtask
   task automatic wr(input logic [12:0] i, input logic [7:0] d);
      acc(1'b1, ad(i), {24'h00_0000, d});
   endtask
   task automatic rdc(input logic [12:0] i, input logic [7:0] e);
      acc(1'b0, ad(i), 32'h0000_0000);
      `CHK(rdat, {24'h00_0000, e})
   endtask
   task automatic refuse(input logic w, input logic [31:0] a);
      acc(w, a, 32'h0000_00FF);
      `CHK({rerr, rdat}, 33'h1_0000_0000)
   endtask
   // Write control, send np pulses, compare resync and marker counts
   task automatic run(input logic [7:0] c, input int np, input int ers, input int emk);
      int r0;
      int m0;
      int s0;
      wr(`SRS_IDX_CTRL, c);
      r0 = n_rs;
      m0 = n_mk;
      s0 = cyc;
      repeat (np) src_u.pulse(4, 24);
      `CHK(n_rs - r0, ers)
      `CHK(n_mk - m0, emk)
      lat = mk_cyc - s0;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      foreach (ri[i]) begin
         rdc(ri[i], 8'h00);
         acc(1'b1, ad(ri[i]), {24'hFF_FFFF, rv[i]});
         rdc(ri[i], rv[i]);
         wr(ri[i], 8'h00);
      end
      refuse(1'b0, 32'h0000_0004);
      refuse(1'b1, ad(`SRS_IDX_IGNORE) + 32'h0000_0001);
      rdc(`SRS_IDX_IGNORE, 8'h00);
      for (int k = 0; k < 4; k++) begin
         run({3'h0, 2'(k), 3'h4}, 1, 1, 0);
         rdc(`SRS_IDX_CTRL, {3'h0, 2'(k), 3'h0});
      end
      wr(`SRS_IDX_IGNORE, 8'h02);
      run(8'h04, 3, 1, 0);
      wr(`SRS_IDX_IGNORE, 8'h00);
      run(8'h02, 2, 2, 0);
      rdc(`SRS_IDX_CTRL, 8'h02);
      acc(1'b0, ad(`SRS_IDX_MONITOR), 32'h0000_0000);
      `CHK(rdat[7:4] <= 4'h8 && rdat[3:0] <= 4'h8, 1'b1)
      wr(`SRS_IDX_SYNCMODE, 8'h01);
      wr(`SRS_IDX_CBCNT, 8'h80);
      wr(`SRS_IDX_CBF_LO, 8'h05);
      run(8'h04, 1, 0, 1);
      d0 = lat;
      wr(`SRS_IDX_TSDLY, 8'h03);
      run(8'h04, 1, 0, 1);
      `CHK(lat - d0, 3)
      wr(`SRS_IDX_APPMODE, 8'h01);
      run(8'h04, 1, 0, 0);
      wr(`SRS_IDX_APPMODE, 8'h00);
      wr(`SRS_IDX_CBCNT, 8'h00);
      run(8'h04, 1, 0, 0);
      report_and_stop();
   end
endmodule
